// ===== hw/ssioc_top.sv
// Servo sequence I/O control: origin search, interrupt feed, overtravel, emergency stop
`timescale 1ns/1ps
`default_nettype none
module ssioc_top
   import ssioc_pkg::*;
#(
   parameter int unsigned INIT_CNT = INIT_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Sequence pins, asynchronous
   input wire logic external_latch_input,
   input wire logic origin_proximity_input,
   input wire logic forward_inhibit_input,
   input wire logic reverse_inhibit_input,
   input wire logic estop_input,
   // Motion core, same clock
   input wire logic index_pulse,
   input wire logic signed [POS_W-1:0] cur_pos,
   input wire logic motor_moving,
   input wire logic motor_power_on,
   input wire logic servo_on_req,
   input wire logic in_position,
   input wire logic internal_error,
   input wire ssioc_cmd_t cmd,
   output ssioc_drv_t drv,
   output logic [7:0] alarm_code,
   // Sequence outputs
   output logic fault_indicator_output,
   output logic brake_release_output
);
   ssioc_state_t st_ff;
   ssioc_state_t nxt_st;
   logic [NUM_IN-1:0] pins;
   logic [NUM_IN-1:0] raw_s1;
   logic [NUM_IN-1:0] raw_s2;
   logic [NUM_IN-1:0] clean_d;
   logic [NUM_IN-1:0][DEB_W-1:0] cnt_d;

   assign pins = {estop_input, reverse_inhibit_input, forward_inhibit_input,
                  origin_proximity_input, external_latch_input};
   assign raw_s1 = pins;
   assign raw_s2 = st_ff.s1;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++)
      begin : g_deb
         always_comb
         begin
            clean_d[gi] = st_ff.clean[gi];
            cnt_d[gi] = '0;
            if (st_ff.s2[gi] != st_ff.clean[gi])
            begin
               if (st_ff.cnt[gi] >= DEB_W'(DEB_CYCLES - 1))
                  clean_d[gi] = st_ff.s2[gi];
               else
                  cnt_d[gi] = st_ff.cnt[gi] + DEB_W'(1);
            end
         end
      end
   endgenerate

   always_comb
   begin
      logic latch_c;
      logic prox_c;
      logic fwd_ok;
      logic rev_ok;
      logic stop_c;
      logic origin_evt;
      logic latch_evt;
      latch_c = st_ff.clean[IN_LATCH];
      prox_c = st_ff.clean[IN_PROX];
      fwd_ok = st_ff.clean[IN_FWD];
      rev_ok = st_ff.clean[IN_REV];
      stop_c = st_ff.clean[IN_STOP];
      latch_evt = latch_c && !st_ff.latch_prev;
      nxt_st = st_ff;
      nxt_st.s1 = raw_s1;
      nxt_st.s2 = raw_s2;
      nxt_st.clean = clean_d;
      nxt_st.cnt = cnt_d;
      nxt_st.latch_prev = latch_c;
      nxt_st.index_prev = index_pulse;
      nxt_st.drv.origin_set = 1'b0;
      nxt_st.drv.done = 1'b0;
      origin_evt = cmd.use_ext_origin ? latch_evt : (index_pulse && !st_ff.index_prev);
      // hold fault output off during init
      if (!st_ff.init_done)
      begin
         if (st_ff.init_cnt >= INIT_W'(INIT_CNT - 1))
            nxt_st.init_done = 1'b1;
         else
            nxt_st.init_cnt = st_ff.init_cnt + INIT_W'(1);
      end
      case (st_ff.seq)
         SSIOC_IDLE:
         begin
            nxt_st.drv.speed = SSIOC_SPD_STOP;
            if (cmd.search_start && st_ff.init_done)
            begin
               nxt_st.seq = SSIOC_FEED;
               nxt_st.prox_seen = 1'b0;
               nxt_st.drv.speed = SSIOC_SPD_FEED;
            end
            else if (cmd.feed_start && st_ff.init_done)
            begin
               nxt_st.seq = SSIOC_INTR;
               nxt_st.drv.goal = cmd.target;
            end
         end
         SSIOC_FEED:
            if (prox_c)
            begin
               nxt_st.seq = SSIOC_APPR;
               nxt_st.drv.speed = SSIOC_SPD_APPR;
            end
         SSIOC_APPR:
            if (!prox_c)
               nxt_st.seq = SSIOC_WAIT;
         SSIOC_WAIT:
            // first origin event after proximity off
            if (origin_evt)
            begin
               nxt_st.seq = SSIOC_CREEP;
               nxt_st.drv.speed = SSIOC_SPD_CREEP;
               nxt_st.drv.goal = cur_pos + cmd.final_dist;
            end
         SSIOC_CREEP:
            if (in_position)
            begin
               nxt_st.seq = SSIOC_IDLE;
               nxt_st.drv.origin_set = 1'b1;
               nxt_st.drv.done = 1'b1;
               nxt_st.drv.speed = SSIOC_SPD_STOP;
            end
         SSIOC_INTR:
            if (latch_evt)
            begin
               nxt_st.seq = SSIOC_MOVE;
               nxt_st.drv.goal = cur_pos + cmd.ext_dist;
            end
            else if (in_position)
            begin
               nxt_st.seq = SSIOC_IDLE;
               nxt_st.drv.done = 1'b1;
            end
         SSIOC_MOVE:
            if (in_position)
            begin
               nxt_st.seq = SSIOC_IDLE;
               nxt_st.drv.done = 1'b1;
            end
         default:
            nxt_st.seq = SSIOC_IDLE;
      endcase
      nxt_st.drv.busy = (nxt_st.seq != SSIOC_IDLE);
      // direction gating by inhibit inputs
      // Emergency stop removes drive in both directions
      nxt_st.drv.drive_fwd = fwd_ok && cmd.fwd_dir && !stop_c;
      nxt_st.drv.drive_rev = rev_ok && !cmd.fwd_dir && !stop_c;
      // stop and lock on inhibited direction
      nxt_st.drv.servo_lock = (cmd.fwd_dir && !fwd_ok) || (!cmd.fwd_dir && !rev_ok);
      nxt_st.drv.full_torque = nxt_st.drv.servo_lock && !motor_moving;
      nxt_st.drv.dyn_brake = stop_c && motor_moving;
      nxt_st.drv.servo_free = stop_c && !motor_moving;
      if (stop_c)
      begin
         nxt_st.seq = SSIOC_IDLE;
         nxt_st.drv.busy = 1'b0;
         nxt_st.drv.speed = SSIOC_SPD_STOP;
      end
      if (stop_c && motor_power_on)
         nxt_st.alarm = ALARM_ESTOP;
      else if (!stop_c && !internal_error)
         nxt_st.alarm = ALARM_NONE;
      // brake released only when servo on is requested, no stop and no alarm after init; internal_error alone does not hold it
      nxt_st.brake_rel = st_ff.init_done && servo_on_req && !stop_c &&
                         (nxt_st.alarm == ALARM_NONE);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign drv = st_ff.drv;
   assign alarm_code = st_ff.alarm;
   assign fault_indicator_output = st_ff.init_done && (st_ff.alarm == ALARM_NONE) &&
                                   !internal_error;
   assign brake_release_output = st_ff.brake_rel;
endmodule
`default_nettype wire

// ===== common/ssioc_pkg.sv
// Package for the servo sequence I/O control block
// Behaviour
// - In origin search with the external sensor chosen, the latch input replaces the index pulse as origin event.
// - In interrupt feeding, a latch during the move retargets to latched position plus the external final distance.
// - In interrupt feeding, with no latch during the move, the original target is completed unchanged.
// - At search feed speed, proximity going active slows the motor to approach speed.
// - After proximity goes inactive, the first origin event slows to creep and positions over the final distance.
// - When that final positioning completes, the current position becomes the coordinate origin.
// - A direction may be driven only while its inhibit input is asserted.
// - When a direction becomes inhibited, the motor decelerates to a stop and is held in servo lock.
// - After an overtravel stop, the holding torque limit is the motor maximum torque.
// - Overtravel never raises an alarm or touches the fault indicator output.
// - The emergency stop input lets the host force servo off and remove motor power.
// - Emergency stop while rotating brakes dynamically to a stop, then goes servo free.
// - Emergency stop while motor power is on raises alarm code A.28.
// - The fault indicator output is inactive on any error and active in normal operation.
// - The fault indicator output is inactive from power up until initial processing of about 2 s ends.
// - The brake release output carries holding brake timing; the brake is released only while it is active.
package ssioc_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned INIT_TIME_MS = 2000;
   localparam int unsigned INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned DEB_TIME_US = 1;
   localparam int unsigned DEB_CYCLES = DEB_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DEB_W = 8;
   localparam int unsigned INIT_W = 32;
   localparam int unsigned POS_W = 32;
   localparam int unsigned NUM_IN = 5;
   localparam int unsigned IN_LATCH = 0;
   localparam int unsigned IN_PROX = 1;
   localparam int unsigned IN_FWD = 2;
   localparam int unsigned IN_REV = 3;
   localparam int unsigned IN_STOP = 4;
   localparam logic [7:0] ALARM_ESTOP = 8'h28;
   localparam logic [7:0] ALARM_NONE = 8'h00;

   typedef enum logic [2:0] {
      SSIOC_IDLE = 3'h0,
      SSIOC_FEED = 3'h1,
      SSIOC_APPR = 3'h3,
      SSIOC_WAIT = 3'h2,
      SSIOC_CREEP = 3'h6,
      SSIOC_MOVE = 3'h7,
      SSIOC_INTR = 3'h5
   } ssioc_seq_t;

   typedef enum logic [1:0] {
      SSIOC_SPD_STOP = 2'h0,
      SSIOC_SPD_FEED = 2'h1,
      SSIOC_SPD_APPR = 2'h3,
      SSIOC_SPD_CREEP = 2'h2
   } ssioc_speed_t;

   typedef struct packed {
      logic search_start;
      logic use_ext_origin;
      logic feed_start;
      logic signed [POS_W-1:0] target;
      logic signed [POS_W-1:0] final_dist;
      logic signed [POS_W-1:0] ext_dist;
      logic fwd_dir;
   } ssioc_cmd_t;

   typedef struct packed {
      ssioc_speed_t speed;
      logic drive_fwd;
      logic drive_rev;
      logic servo_lock;
      logic full_torque;
      logic dyn_brake;
      logic servo_free;
      logic origin_set;
      logic busy;
      logic done;
      logic signed [POS_W-1:0] goal;
   } ssioc_drv_t;

   typedef struct packed {
      logic [NUM_IN-1:0] s1;
      logic [NUM_IN-1:0] s2;
      logic [NUM_IN-1:0] clean;
      logic [NUM_IN-1:0][DEB_W-1:0] cnt;
      logic [INIT_W-1:0] init_cnt;
      logic init_done;
      ssioc_seq_t seq;
      logic prox_seen;
      logic latch_prev;
      logic index_prev;
      logic [7:0] alarm;
      logic brake_rel;
      ssioc_drv_t drv;
   } ssioc_state_t;
endpackage

// ===== verification/ssioc_asserts.sv
// Checker of the port relations of the sequence I/O block
`timescale 1ns/1ps
`default_nettype none
module ssioc_asserts
   import ssioc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Inputs watched
   input wire logic servo_on_req,
   input wire logic internal_error,
   input wire logic signed [POS_W-1:0] cur_pos,
   input wire ssioc_cmd_t cmd,
   // Outputs watched
   input wire ssioc_drv_t drv,
   input wire logic [7:0] alarm_code,
   input wire logic fault_indicator_output,
   input wire logic brake_release_output
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_error_fault: assert property (internal_error |-> !fault_indicator_output)
      else $error("fault output high during an error");
   a_alarm_fault: assert property (alarm_code == ALARM_ESTOP |-> !fault_indicator_output)
      else $error("fault output high with stop alarm");
   // Registered output, so it answers the request of the cycle before
   a_brake_hold: assert property (brake_release_output |-> $past(servo_on_req))
      else $error("brake released without servo request");
   a_done_pulse: assert property (drv.done |=> !drv.done)
      else $error("done longer than one cycle");
   a_origin_done: assert property (drv.origin_set |-> drv.done)
      else $error("origin set outside completion");
   a_lock_torque: assert property (drv.full_torque |-> drv.servo_lock)
      else $error("full torque without servo lock");
   a_free_nodrive: assert property (drv.servo_free |-> !drv.drive_fwd && !drv.drive_rev)
      else $error("drive enabled while servo free");
   a_start_busy: assert property ($rose(drv.busy) |-> $past(cmd.search_start || cmd.feed_start))
      else $error("busy without a start");
   a_creep_goal: assert property (drv.speed == SSIOC_SPD_CREEP && $past(drv.speed) != SSIOC_SPD_CREEP
      |-> drv.goal == $past(cur_pos + cmd.final_dist))
      else $error("creep goal not position plus final distance");
endmodule
bind ssioc_top ssioc_asserts u_chk (
   .clk(clk), .rst(rst), .servo_on_req(servo_on_req), .internal_error(internal_error),
   .cur_pos(cur_pos), .cmd(cmd), .drv(drv), .alarm_code(alarm_code),
   .fault_indicator_output(fault_indicator_output), .brake_release_output(brake_release_output)
);
`default_nettype wire

// ===== verification/ssioc_far.sv
// Motion core and holding brake stand-in facing the block
`timescale 1ns/1ps
`default_nettype none
module ssioc_far
   import ssioc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Block side
   input wire ssioc_drv_t drv,
   input wire logic brake_release_output,
   // Stall from the bench, freezes the axis
   input wire logic hold,
   // Motion core side
   output logic signed [POS_W-1:0] cur_pos,
   output logic in_position,
   output logic motor_moving,
   output logic brake_open
);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cur_pos <= '0;
         brake_open <= 1'b0;
      end
      else
      begin
         // One count a cycle keeps moves short but still visible
         if (drv.busy && !hold && cur_pos != drv.goal)
            cur_pos <= (cur_pos < drv.goal) ? cur_pos + 1 : cur_pos - 1;
         brake_open <= brake_release_output;
      end
   end
   assign in_position = drv.busy && !hold && cur_pos == drv.goal;
   assign motor_moving = drv.busy && !hold && !in_position;
endmodule
`default_nettype wire

// ===== verification/ssioc_top_tb.sv
// Self-checking bench of the servo sequence I/O block
`timescale 1ns/1ps
`default_nettype none
module ssioc_top_tb;
   import ssioc_pkg::*;
   localparam int W = DEB_CYCLES + 10;
   logic clk, rst, lat, prox, fwd, rev, stop, idx, pwr, son, err, hold, inpos, mov, bopen;
   logic signed [POS_W-1:0] pos;
   ssioc_cmd_t cmd;
   ssioc_drv_t drv;
   logic [7:0] code;
   logic fault, brake;
   int miscompares = 0;
   int n_checks = 0;
   ssioc_top #(.INIT_CNT(20)) u_dut (.clk(clk), .rst(rst), .external_latch_input(lat),
      .origin_proximity_input(prox), .forward_inhibit_input(fwd), .reverse_inhibit_input(rev),
      .estop_input(stop), .index_pulse(idx), .cur_pos(pos), .motor_moving(mov),
      .motor_power_on(pwr), .servo_on_req(son), .in_position(inpos), .internal_error(err),
      .cmd(cmd), .drv(drv), .alarm_code(code), .fault_indicator_output(fault),
      .brake_release_output(brake));
   ssioc_far u_far (.clk(clk), .rst(rst), .drv(drv), .brake_release_output(brake),
      .hold(hold), .cur_pos(pos), .in_position(inpos), .motor_moving(mov), .brake_open(bopen));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic fin(input logic org);
      hold = 1'b0;
      for (int k = 0; k < 300 && drv.done !== 1'b1; k++) @(negedge clk);
      chk(drv.done, 1'b1);
      chk(drv.origin_set, org);
   endtask
   task automatic t_search(input logic src);
      cmd.use_ext_origin = src;
      cmd.final_dist = 8;
      cmd.search_start = 1'b1;
      hold = 1'b1;
      cyc(1);
      cmd.search_start = 1'b0;
      cyc(1);
      chk(drv.speed, SSIOC_SPD_FEED);
      prox = 1'b1;
      cyc(W);
      chk(drv.speed, SSIOC_SPD_APPR);
      prox = 1'b0;
      cyc(W);
      lat = src;
      idx = !src;
      cyc(src ? W : 1);
      lat = 1'b0;
      idx = 1'b0;
      // Let the latch input settle low so the next latch is a fresh edge
      cyc(W);
      chk(drv.speed, SSIOC_SPD_CREEP);
      chk(drv.goal, pos + 8);
      fin(1'b1);
   endtask
   task automatic t_feed(input logic latch);
      logic signed [POS_W-1:0] p0;
      p0 = pos;
      cmd.target = p0 + 40;
      cmd.ext_dist = 6;
      cmd.feed_start = 1'b1;
      hold = 1'b1;
      cyc(1);
      cmd.feed_start = 1'b0;
      cyc(1);
      chk(drv.goal, p0 + 40);
      lat = latch;
      cyc(W);
      lat = 1'b0;
      chk(drv.goal, latch ? p0 + 6 : p0 + 40);
      fin(1'b0);
   endtask
   task automatic t_otr(input logic dir);
      cmd.fwd_dir = dir;
      fwd = fwd & ~dir;
      rev = rev & dir;
      cyc(W);
      chk(dir ? drv.drive_fwd : drv.drive_rev, 1'b0);
      chk(drv.servo_lock, 1'b1);
      chk(drv.full_torque, 1'b1);
      chk({fault, code}, 9'h100);
      fwd = 1'b1;
      rev = 1'b1;
      cyc(W);
   endtask
   task automatic t_stop;
      stop = 1'b1;
      cyc(W);
      chk(code, ALARM_ESTOP);
      chk(fault, 1'b0);
      chk(drv.servo_free, 1'b1);
      chk({brake, bopen}, 2'h0);
      stop = 1'b0;
      err = 1'b1;
      cyc(W);
      chk({fault, code}, 9'h028);
      err = 1'b0;
      cyc(3);
      chk({fault, code, brake}, 10'h201);
   endtask
   initial
   begin
      {rst, lat, prox, stop, idx, err, hold} = '0;
      {fwd, rev, son, pwr} = 4'hF;
      cmd = '0;
      rst = 1'b1;
      cyc(12);
      rst = 1'b0;
      cyc(5);
      chk(fault, 1'b0);
      cyc(25);
      chk({fault, brake, bopen}, 3'h7);
      t_search(1'b0);
      t_search(1'b1);
      t_feed(1'b1);
      t_feed(1'b0);
      t_otr(1'b1);
      t_otr(1'b0);
      t_stop;
      give_verdict;
   end
   // Whole run needs about 4000 cycles; this cuts a hang well beyond that
   initial
   begin
      #100000;
      miscompares++;
      give_verdict;
   end
endmodule
`default_nettype wire
